// File: logic/dcs_regs.vh
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
// Register byte offsets
`define DCS_OFF_PKT_STATUS   8'h74
`define DCS_OFF_TO_CFG       8'h78
`define DCS_OFF_HS_RD_WAIT   8'h7C
`define DCS_OFF_LP_RD_WAIT   8'h80
`define DCS_OFF_HS_WR_WAIT   8'h84
`define DCS_OFF_LP_WR_WAIT   8'h88
`define DCS_OFF_IRQ_STATUS   8'hA8
`define DCS_OFF_IRQ_MASK     8'hAC
`define DCS_OFF_TO_DIV       8'hB0
// Status bit positions
`define DCS_BIT_RD_BUSY      6
`define DCS_BIT_RPLD_FULL    5
`define DCS_BIT_RPLD_EMPTY   4
`define DCS_BIT_WPLD_FULL    3
`define DCS_BIT_WPLD_EMPTY   2
`define DCS_BIT_CMD_FULL     1
`define DCS_BIT_CMD_EMPTY    0
// Field positions
`define DCS_BIT_FRAME_MODE   24
`define DCS_IRQ_HS_TX_TO     0
`define DCS_IRQ_LP_RX_TO     1
// Reset values
`define DCS_RST_STATUS       7'h15
`define DCS_RST_DIV          8'h01
`endif

// File: logic/dcs_status_timeouts.v
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_regs.vh"
module dcs_status_timeouts (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // FIFO state from the datapath
    input  wire        cmd_fifo_full,
    input  wire        cmd_fifo_empty,
    input  wire        wpld_fifo_full,
    input  wire        wpld_fifo_empty,
    input  wire        rpld_fifo_full,
    input  wire        rpld_fifo_empty,
    // Read command tracking
    input  wire        rd_cmd_issue,
    input  wire        rd_resp_stored,
    // Link operation events
    input  wire        hs_tx_active,
    input  wire        lp_rx_active,
    input  wire        op_done_hs_rd,
    input  wire        op_done_lp_rd,
    input  wire        op_done_hs_wr,
    input  wire        op_done_lp_wr,
    input  wire        phy_stop_state,
    // Frame sync and pixel FIFO (other domain, synchronised)
    input  wire        frame_sync,
    input  wire        pix_fifo_empty,
    // Outputs to packet scheduler and system
    output reg         link_hold,
    output reg         irq
);
    // Two-stage synchronisers for inputs from other domains.
    // Frame sync and the pixel FIFO empty flag come from the pixel
    // clock side; only the second stage and the edge register behind
    // it are read, so a metastable first stage never reaches logic.
    // The edge register resets low, the idle level of frame sync.
    reg [1:0] fs_s1_r;
    reg [1:0] fs_s2_r;
    reg       fs_prev_r;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fs_s1_r   <= 2'h0;
            fs_s2_r   <= 2'h0;
            fs_prev_r <= 1'b0;
        end else begin
            fs_s1_r   <= {pix_fifo_empty, frame_sync};
            fs_s2_r   <= fs_s1_r;
            fs_prev_r <= fs_s2_r[0];
        end
    end
    // Rise and fall pulses of the synchronised frame sync, one
    // cycle wide; they feed the once-per-frame arming only
    wire fs_rise = fs_s2_r[0] & ~fs_prev_r;
    wire fs_fall = ~fs_s2_r[0] & fs_prev_r;
    wire pix_empty = fs_s2_r[1];

    // Software registers.
    // All wait fields reset to zero, which means no link hold at all;
    // a zero contention limit likewise leaves detection switched off.
    // Reserved bits are not stored and read back as zero.
    reg [31:0] to_cfg_r;      // HS tx / LP rx timeout counts
    reg        hs_rd_wait_r;  // One-bit field, as laid out
    reg [15:0] lp_rd_wait_r;
    reg [15:0] hs_wr_wait_r;
    reg        frame_mode_r;  // Once-per-frame wait mode
    reg [15:0] lp_wr_wait_r;
    reg [1:0]  irq_stat_r;    // Sticky contention errors
    reg [1:0]  irq_mask_r;
    reg [7:0]  div_r;         // Timeout clock divider
    reg [6:0]  status_r;      // Registered FIFO/busy status

    // AHB address phase capture.
    // Only the low address byte is decoded, so the bank aliases every
    // 256 bytes. The transfer size is not looked at: every register is
    // a whole word and narrower writes are treated as word writes.
    // Writes land one edge after the address phase, when hwdata stands.
    // hresp never signals an error, so unmapped accesses are harmless.
    reg        wr_pend_r;
    reg        rd_pend_r;
    reg [7:0]  addr_r;
    wire xfer = hsel & hready & htrans[1];
    wire do_wr = wr_pend_r;
    wire [1:0] w1c = (do_wr && addr_r == `DCS_OFF_IRQ_STATUS)
                     ? hwdata[1:0] : 2'h0;

    // Status capture, reset values show empty FIFOs.
    // The FIFO flags are registered once so that a read sees a value
    // that stood for a whole cycle; the cost is one cycle of lag
    // between the datapath and what software reads.
    // The busy bit is state of its own, set and cleared by pulses.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= `DCS_RST_STATUS;
        end else begin
            status_r[`DCS_BIT_RPLD_FULL]  <= rpld_fifo_full;
            status_r[`DCS_BIT_RPLD_EMPTY] <= rpld_fifo_empty;
            status_r[`DCS_BIT_WPLD_FULL]  <= wpld_fifo_full;
            status_r[`DCS_BIT_WPLD_EMPTY] <= wpld_fifo_empty;
            status_r[`DCS_BIT_CMD_FULL]   <= cmd_fifo_full;
            status_r[`DCS_BIT_CMD_EMPTY]  <= cmd_fifo_empty;
            // Issue wins over completion in the same cycle
            if (rd_cmd_issue)
                status_r[`DCS_BIT_RD_BUSY] <= 1'b1;
            else if (rd_resp_stored)
                status_r[`DCS_BIT_RD_BUSY] <= 1'b0;
        end
    end

    // Timeout clock divider: one tick every div_r cycles.
    // A divider of zero behaves as one, so the tick can never stall;
    // changing the divider mid-count takes effect on the count in progress.
    // Contention limits are counted in these ticks, not in clocks.
    // With the reset value of one a tick occurs on every clock.
    reg [7:0] div_cnt_r;
    reg       tick_r;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_r <= 8'h00;
            tick_r    <= 1'b0;
        end else if (div_cnt_r + 8'h01 >= div_r) begin
            div_cnt_r <= 8'h00;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            tick_r    <= 1'b0;
        end
    end

    // Contention timeout counters, one per direction.
    // Entry 0 watches high-speed transmit, entry 1 low-power receive.
    // A counter restarts whenever its direction goes idle, so only a
    // run of activity as long as the limit raises an error. It stops
    // at all ones rather than wrapping, so one long run flags only
    // once instead of once per wrap of the counter.
    reg  [15:0] to_cnt_r [0:1];
    wire [1:0]  to_act = {lp_rx_active, hs_tx_active};
    wire [15:0] to_lim [0:1];
    assign to_lim[0] = to_cfg_r[31:16];
    assign to_lim[1] = to_cfg_r[15:0];
    wire [1:0]  to_hit;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_to
            // Counts divided ticks while the direction is active
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    to_cnt_r[g] <= 16'h0000;
                end else if (!to_act[g]) begin
                    to_cnt_r[g] <= 16'h0000;
                end else if (tick_r && to_cnt_r[g] != 16'hFFFF) begin
                    to_cnt_r[g] <= to_cnt_r[g] + 16'h0001;
                end
            end
            // A zero limit disables detection
            assign to_hit[g] = to_act[g] && tick_r &&
                               to_lim[g] != 16'h0000 &&
                               to_cnt_r[g] + 16'h0001 == to_lim[g];
        end
    endgenerate

    // Once-per-frame tracking for the HS write wait.
    // The frame-sync input must show a complete pulse, rise and then
    // fall, before one write wait is allowed for the frame; a level
    // that is merely high does not arm the wait.
    reg  fs_rose_r;        // Sync rise seen, waiting for the fall
    reg  frame_armed_r;    // One HS write wait owed for this frame
    wire wait_start_hs_wr; // HS write done and, in frame mode, armed with pixel FIFO empty
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fs_rose_r     <= 1'b0;
            frame_armed_r <= 1'b0;
        end else begin
            // Latch the rise; the fall that follows arms the frame
            if (fs_rise)
                fs_rose_r <= 1'b1;
            // Sync must rise then fall before arming
            if (fs_fall && fs_rose_r) begin
                fs_rose_r     <= 1'b0;
                frame_armed_r <= 1'b1;
            end else if (wait_start_hs_wr) begin
                frame_armed_r <= 1'b0;
            end
        end
    end

    // Link-still wait engine, counted on each clock from Stop state.
    // Lane byte clock cycles are stood in for by the single clock.
    // An operation with a nonzero wait raises link_hold at once; the
    // count itself only begins once the PHY reports the Stop state,
    // so a slow lane turn-back lengthens the hold but not the count.
    // Operations ending while a wait runs are not queued: the link is
    // still held, and software sees no interrupt from any wait.
    localparam ST_IDLE  = 3'b001;
    localparam ST_PEND  = 3'b010;
    localparam ST_COUNT = 3'b100;
    reg [2:0]  st_r;
    reg [15:0] wait_len_r;
    reg [15:0] wait_cnt_r;
    // HS write wait is gated per frame when the mode bit is set
    assign wait_start_hs_wr = op_done_hs_wr &&
        (!frame_mode_r || (frame_armed_r && pix_empty));
    wire any_done = op_done_hs_rd | op_done_lp_rd |
                    wait_start_hs_wr | op_done_lp_wr;
    // Wait length of the operation just sent. Only one operation
    // ends per cycle in practice; should two coincide, reads take
    // precedence over writes and high-speed over low-power.
    reg  [15:0] sel_len;
    always @* begin
        sel_len = 16'h0000;
        if (op_done_hs_rd)
            sel_len = {15'h0000, hs_rd_wait_r};
        else if (op_done_lp_rd)
            sel_len = lp_rd_wait_r;
        else if (wait_start_hs_wr)
            sel_len = hs_wr_wait_r;
        else if (op_done_lp_wr)
            sel_len = lp_wr_wait_r;
    end
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r       <= ST_IDLE;
            wait_len_r <= 16'h0000;
            wait_cnt_r <= 16'h0000;
            link_hold  <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    // Zero length means no hold at all
                    if (any_done && sel_len != 16'h0000) begin
                        wait_len_r <= sel_len;
                        link_hold  <= 1'b1;
                        st_r       <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    // Counting waits for the PHY Stop state; the
                    // first counted cycle follows the one in which
                    // Stop is seen
                    if (phy_stop_state) begin
                        wait_cnt_r <= 16'h0001;
                        st_r       <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    // Ends after exactly wait_len_r counted cycles
                    if (wait_cnt_r >= wait_len_r) begin
                        link_hold <= 1'b0;
                        st_r      <= ST_IDLE;
                    end else begin
                        wait_cnt_r <= wait_cnt_r + 16'h0001;
                    end
                end
                // Illegal codes fall back to idle with the link free
                default: begin
                    st_r      <= ST_IDLE;
                    link_hold <= 1'b0;
                end
            endcase
        end
    end

    // AHB write and sticky status; set beats clear.
    // A timeout that fires in the very cycle software writes a one to
    // clear its bit keeps the bit set, so no error is ever lost.
    // The mode bit shares its word with the HS write wait, so both
    // change together on one write.
    // Writes to the status word and to unmapped offsets are dropped.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_r    <= 1'b0;
            rd_pend_r    <= 1'b0;
            addr_r       <= 8'h00;
            to_cfg_r     <= 32'h0000_0000;
            hs_rd_wait_r <= 1'b0;
            lp_rd_wait_r <= 16'h0000;
            hs_wr_wait_r <= 16'h0000;
            frame_mode_r <= 1'b0;
            lp_wr_wait_r <= 16'h0000;
            irq_mask_r   <= 2'h0;
            irq_stat_r   <= 2'h0;
            div_r        <= `DCS_RST_DIV;
        end else begin
            wr_pend_r <= xfer & hwrite;
            rd_pend_r <= xfer & ~hwrite;
            if (xfer)
                addr_r <= haddr[7:0];
            irq_stat_r <= (irq_stat_r & ~w1c) | to_hit;
            if (do_wr) begin
                case (addr_r)
                    `DCS_OFF_TO_CFG:     to_cfg_r <= hwdata;
                    `DCS_OFF_HS_RD_WAIT: hs_rd_wait_r <= hwdata[0];
                    `DCS_OFF_LP_RD_WAIT: lp_rd_wait_r <= hwdata[15:0];
                    `DCS_OFF_HS_WR_WAIT: begin
                        hs_wr_wait_r <= hwdata[15:0];
                        frame_mode_r <= hwdata[`DCS_BIT_FRAME_MODE];
                    end
                    `DCS_OFF_LP_WR_WAIT: lp_wr_wait_r <= hwdata[15:0];
                    `DCS_OFF_IRQ_MASK:   irq_mask_r <= hwdata[1:0];
                    `DCS_OFF_TO_DIV:     div_r <= hwdata[7:0];
                    default: begin
                        // Status and unmapped addresses ignore writes
                    end
                endcase
            end
        end
    end

    // Read mux, registered in the address phase edge.
    // Decoding from the address phase lets hrdata come from a flop
    // and still be valid in the data phase with no wait state.
    // The status word shows what was registered a cycle earlier.
    // Unmapped offsets read as zero.
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `DCS_OFF_PKT_STATUS: rd_mux = {25'h0000000, status_r};
            `DCS_OFF_TO_CFG:     rd_mux = to_cfg_r;
            `DCS_OFF_HS_RD_WAIT: rd_mux = {31'h00000000, hs_rd_wait_r};
            `DCS_OFF_LP_RD_WAIT: rd_mux = {16'h0000, lp_rd_wait_r};
            `DCS_OFF_HS_WR_WAIT:
                rd_mux = {7'h00, frame_mode_r, 8'h00, hs_wr_wait_r};
            `DCS_OFF_LP_WR_WAIT: rd_mux = {16'h0000, lp_wr_wait_r};
            `DCS_OFF_IRQ_STATUS: rd_mux = {30'h00000000, irq_stat_r};
            `DCS_OFF_IRQ_MASK:   rd_mux = {30'h00000000, irq_mask_r};
            `DCS_OFF_TO_DIV:     rd_mux = {24'h000000, div_r};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus outputs; zero wait states, always OKAY.
    // hrdata holds its value until the next read is taken.
    // The interrupt is registered too, so it follows the status and
    // mask one cycle late; it is a level, high while an unmasked
    // error bit stays set.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            irq       <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (xfer && !hwrite)
                hrdata <= rd_mux;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule
`default_nettype wire

// File: verification/dcs_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_link_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Link activity seen from the controller
    input  wire logic op_sent,
    input  wire logic link_active,
    input  wire logic slow,
    // PHY lane state
    output logic      phy_stop_state
);
    logic [2:0] lag_r; // Cycles until the lanes settle into Stop
    // A slow peripheral takes longer to return the lanes to Stop
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) lag_r <= 3'h0;
        else if (op_sent) lag_r <= slow ? 3'h6 : 3'h1;
        else if (lag_r != 3'h0) lag_r <= lag_r - 3'h1;
    end
    assign phy_stop_state = !link_active && lag_r == 3'h0;
endmodule
`default_nettype wire

// File: verification/dcs_status_timeouts_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_status_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Bus side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // FIFO flags
    input wire logic        rpld_fifo_full,
    input wire logic        rpld_fifo_empty,
    input wire logic        wpld_fifo_full,
    input wire logic        wpld_fifo_empty,
    input wire logic        cmd_fifo_full,
    input wire logic        cmd_fifo_empty,
    // Link events and outputs
    input wire logic        op_done_hs_rd,
    input wire logic        op_done_lp_rd,
    input wire logic        op_done_hs_wr,
    input wire logic        op_done_lp_wr,
    input wire logic        phy_stop_state,
    input wire logic        link_hold,
    input wire logic        irq
);
    // Taken transfers and the flag word as the status layout packs it
    wire       take  = hsel && hready && htrans[1];
    wire       rd_ap = take && !hwrite;
    wire       wr_ap = take && hwrite;
    wire [5:0] flags = {rpld_fifo_full, rpld_fifo_empty, wpld_fifo_full,
                        wpld_fifo_empty, cmd_fifo_full, cmd_fifo_empty};
    wire       any_op = op_done_hs_rd | op_done_lp_rd |
                        op_done_hs_wr | op_done_lp_wr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait");
    a_resp_okay: assert property (!hresp)
        else $error("slave gave an error response");
    a_status_flags: assert property (
        rd_ap && haddr[7:0] == 8'h74 && $stable(flags)
        |=> hrdata[5:0] == $past(flags)) else $error("flag bits wrong");
    a_status_spare: assert property (rd_ap && haddr[7:0] == 8'h74
        |=> hrdata[31:7] == 25'h0) else $error("spare status bits set");
    a_unmapped_zero: assert property (rd_ap && haddr[7:0] == 8'h90
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_hold_cause: assert property ($rose(link_hold) |-> $past(any_op))
        else $error("link held without an operation");
    a_hold_in_stop: assert property (
        link_hold && !phy_stop_state |=> link_hold)
        else $error("hold ended before stop state");
    a_irq_sticky: assert property (
        irq && !wr_ap && !$past(wr_ap) && !$past(wr_ap, 2) |=> irq)
        else $error("interrupt dropped without a write");
    // Main scenarios reached
    c_hold: cover property ($rose(link_hold));
    c_irq_clear: cover property ($fell(irq));
    c_status_read: cover property (rd_ap && haddr[7:0] == 8'h74);
endmodule
bind dcs_status_timeouts dcs_status_props dcs_status_props_i (.*);
`default_nettype wire

// File: verification/dcs_status_timeouts_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_status_timeouts_tb;
    logic        ref_clk = 1'b0;   // 10 MHz clock
    logic        rstn    = 1'b0;   // Reset, active low
    logic        hsel    = 1'b0;   // Bus master drive
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [5:0]  fl      = 6'h15;  // FIFO flags, empty after reset
    logic [3:0]  op      = 4'h0;   // Operation-sent pulses
    logic        rd_iss  = 1'b0;
    logic        rd_sto  = 1'b0;
    logic        hs_act  = 1'b0;
    logic        lp_act  = 1'b0;
    logic        fsync   = 1'b0;
    logic        pix_emp = 1'b0;
    logic        slow    = 1'b0;
    logic [31:0] q;                // Last read data
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, phy_stop_state, link_hold, irq;
    int          bad_count = 0;
    int          n_checks  = 0;
    always #50 ref_clk = ~ref_clk;
    dcs_status_timeouts dcs_status_timeouts_i (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cmd_fifo_full(fl[1]), .cmd_fifo_empty(fl[0]),
        .wpld_fifo_full(fl[3]), .wpld_fifo_empty(fl[2]),
        .rpld_fifo_full(fl[5]), .rpld_fifo_empty(fl[4]),
        .rd_cmd_issue(rd_iss), .rd_resp_stored(rd_sto),
        .hs_tx_active(hs_act), .lp_rx_active(lp_act),
        .op_done_hs_rd(op[0]), .op_done_lp_rd(op[1]),
        .op_done_hs_wr(op[2]), .op_done_lp_wr(op[3]),
        .phy_stop_state(phy_stop_state), .frame_sync(fsync),
        .pix_fifo_empty(pix_emp), .link_hold(link_hold), .irq(irq));
    dcs_link_model dcs_link_model_i (
        .ref_clk(ref_clk), .rstn(rstn), .op_sent(|op),
        .link_active(hs_act | lp_act), .slow(slow),
        .phy_stop_state(phy_stop_state));
    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // One single transfer; hold each phase until hready is seen high
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Pulse one operation and count held cycles spent in Stop
    task automatic run_op(input int i, input int e);
        int n;
        n = 0;
        op[i] <= 1'b1;
        @(posedge ref_clk) op[i] <= 1'b0;
        repeat (40) begin
            @(negedge ref_clk);
            if (link_hold === 1'b1 && phy_stop_state === 1'b1) n++;
        end
        @(posedge ref_clk);
        // The cycle in which Stop is first seen is held but not counted
        chk(n, (e == 0) ? 0 : e + 1);
    endtask
    // Reset values, flag mirroring, read-back masks and refusals
    task automatic t_regs;
        logic [7:0]  adr[5] = '{8'h78, 8'h7C, 8'h80, 8'h84, 8'h88};
        logic [31:0] msk[5] = '{32'hFFFFFFFF, 32'h1, 32'hFFFF,
                                32'h0100FFFF, 32'hFFFF};
        rd_chk(8'h74, 32'h15);
        fl <= 6'h2A;
        repeat (2) @(posedge ref_clk);
        rd_chk(8'h74, 32'h2A);
        fl <= 6'h15;
        for (int i = 0; i < 5; i++) begin
            rd_chk(adr[i], 32'h0);
            ahb(1'b1, adr[i], 32'hFFFFFFFF);
            rd_chk(adr[i], msk[i]);
        end
        ahb(1'b1, 8'h90, 32'hFFFFFFFF);
        rd_chk(8'h90, 32'h0);
        ahb(1'b1, 8'h74, 32'hFFFFFFFF);
        rd_chk(8'h74, 32'h15);
    endtask
    // Read-pending flag follows issue and completion
    task automatic t_busy;
        rd_iss <= 1'b1;
        @(posedge ref_clk) rd_iss <= 1'b0;
        rd_chk(8'h74, 32'h55);
        rd_chk(8'h74, 32'h55);
        rd_sto <= 1'b1;
        @(posedge ref_clk) rd_sto <= 1'b0;
        rd_chk(8'h74, 32'h15);
    endtask
    // Quiet periods per operation kind, then once-per-frame mode
    task automatic t_wait;
        logic [7:0] wadr[4] = '{8'h7C, 8'h80, 8'h84, 8'h88};
        int         wlen[4] = '{1, 5, 9, 3};
        for (int i = 0; i < 4; i++) begin
            slow <= (i > 1);
            ahb(1'b1, wadr[i], wlen[i]);
            run_op(i, wlen[i]);
        end
        ahb(1'b1, 8'h88, 32'h0);
        run_op(3, 0);
        ahb(1'b1, 8'h84, 32'h01000004);
        run_op(2, 0);
        fsync <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fsync <= 1'b0;
        pix_emp <= 1'b1;
        repeat (4) @(posedge ref_clk);
        run_op(2, 4);
        run_op(2, 0);
    endtask
    // Contention timers raise sticky, maskable error bits
    task automatic t_irq;
        ahb(1'b1, 8'hB0, 32'h1);
        ahb(1'b1, 8'hAC, 32'h3);
        ahb(1'b1, 8'h78, 32'h00040003);
        lp_act <= 1'b1;
        repeat (2) @(posedge ref_clk);
        lp_act <= 1'b0;
        rd_chk(8'hA8, 32'h0);
        hs_act <= 1'b1;
        repeat (10) @(posedge ref_clk);
        hs_act <= 1'b0;
        rd_chk(8'hA8, 32'h1);
        chk({31'h0, irq}, 32'h1);
        ahb(1'b1, 8'hA8, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b1, 8'hAC, 32'h1);
        lp_act <= 1'b1;
        repeat (10) @(posedge ref_clk);
        lp_act <= 1'b0;
        rd_chk(8'hA8, 32'h2);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b1, 8'hA8, 32'h2);
        rd_chk(8'hA8, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_busy();
        t_wait();
        t_irq();
        give_verdict();
    end
    // Whole run needs well under 3000 cycles
    initial begin
        #1000000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
